//--- logic/qpc_pkg.sv
package qpc_pkg;
   // Array sizes
   localparam int POTS = 4;
   localparam int SETS = 4;
   localparam int POS_W = 6;
   localparam int TAPS = 64;
   localparam int BYTE_BITS = 8;
   // Instruction byte fields
   localparam int OP_MSB = 7;
   localparam int OP_LSB = 4;
   localparam int REG_MSB = 3;
   localparam int REG_LSB = 2;
   localparam int POT_MSB = 1;
   localparam int POT_LSB = 0;
   // Address byte fields
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int SEL_MSB = 3;
   localparam int SEL_LSB = 0;
   // Device type code, value is arbitrary
   localparam logic [3:0] DEVICE_TYPE_DEF = 4'hA;
   // Opcodes
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'hA;
   localparam logic [3:0] OP_RD_SET = 4'hB;
   localparam logic [3:0] OP_WR_SET = 4'hC;
   localparam logic [3:0] OP_LOAD_SET = 4'hD;
   localparam logic [3:0] OP_SAVE_WIPER = 4'hE;
   localparam logic [3:0] OP_GLOAD_SET = 4'h1;
   localparam logic [3:0] OP_GSAVE_WIPER = 4'h8;
   localparam logic [3:0] OP_STEP = 4'h2;
   // Wiper limits
   localparam logic [5:0] WIPER_MAX = 6'h3F;
   localparam logic [5:0] WIPER_MIN = 6'h00;
   // Reset values
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [7:0] SHIFT_RST = 8'h00;
   localparam logic [3:0] LINE_RST = 4'hF;
   // Timing: longest write time, rounded down to cycles
   localparam int CLK_KHZ = 50000;
   localparam int NV_WRITE_MS = 10;
   localparam int NV_WRITE_CYCLES = NV_WRITE_MS * CLK_KHZ;
   // Link state, one-hot
   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_ADDR  = 9'h002,
      ST_ACK_A = 9'h004,
      ST_INSTR = 9'h008,
      ST_ACK_I = 9'h010,
      ST_DRX   = 9'h020,
      ST_ACK_D = 9'h040,
      ST_DTX   = 9'h080,
      ST_STEP  = 9'h100
   } qpc_state_type;
   // Opcodes that the block accepts
   function automatic logic op_known(input logic [3:0] op);
      case (op)
         OP_RD_WIPER, OP_WR_WIPER, OP_RD_SET, OP_WR_SET, OP_LOAD_SET,
         OP_SAVE_WIPER, OP_GLOAD_SET, OP_GSAVE_WIPER, OP_STEP: op_known = 1'b1;
         default: op_known = 1'b0;
      endcase
   endfunction : op_known
   // One closed switch per wiper value
   function automatic logic [63:0] tap_decode(input logic [5:0] pos);
      tap_decode = 64'h1 << pos;
   endfunction : tap_decode
endpackage : qpc_pkg

//--- logic/qpc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Line events from the sampler to the command logic
interface qpc_link_if;
   logic scl_rise;  // Clock line went high
   logic scl_fall;  // Clock line went low
   logic start;     // Data fell while clock high
   logic stop;      // Data rose while clock high
   logic sda_level; // Synchronised data level
   modport rx (output scl_rise, output scl_fall, output start,
      output stop, output sda_level);
   modport core (input scl_rise, input scl_fall, input start,
      input stop, input sda_level);
endinterface : qpc_link_if
`default_nettype wire

//--- logic/qpc_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
// Samples both bus lines and finds their edges
module qpc_link_rx (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic scl_in,
   input wire logic sda_in,
   qpc_link_if.rx link
);
   // Bit 0 synchroniser, bit 1 stable, bit 2 previous
   logic [2:0] scl_q;
   logic [2:0] scl_d;
   logic [2:0] sda_q;
   logic [2:0] sda_d;

   // Shift chains; idle bus reads high
   always_comb begin
      scl_d = {scl_q[1:0], scl_in};
      sda_d = {sda_q[1:0], sda_in};
      // Pin reaches the first flop untouched; later stages idle high
      if (reset_in) begin
         scl_d[2:1] = 2'h3;
         sda_d[2:1] = 2'h3;
      end
   end

   // Register only
   always_ff @(posedge clock_in) begin
      scl_q <= scl_d;
      sda_q <= sda_d;
   end

   // Edge events; stage 0 never feeds these gates
   assign link.scl_rise = scl_q[1] & ~scl_q[2];
   assign link.scl_fall = ~scl_q[1] & scl_q[2];
   assign link.start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   assign link.stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
   assign link.sda_level = sda_q[1];
endmodule : qpc_link_rx
`default_nettype wire

//--- logic/qpc_core.sv
`timescale 1ns/1ps
`default_nettype none
// Command logic of four digital pots behind a two-wire link
module qpc_core #(
   parameter int NV_WRITE_CYCLES = qpc_pkg::NV_WRITE_CYCLES,
   parameter logic [3:0] DEVICE_TYPE = qpc_pkg::DEVICE_TYPE_DEF
) (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n_out,
   input wire logic [3:0] device_select_bits_in,
   output logic [23:0] wiper_position_bits_out,
   output logic [255:0] tap_select_out,
   output logic nv_busy_out
);
   localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);

   qpc_link_if lnk ();

   // Line sampler
   qpc_link_rx u_rx (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .link(lnk)
   );

   qpc_pkg::qpc_state_type state_q, state_d; // Link phase
   logic [3:0] bit_cnt_q, bit_cnt_d;   // Bits moved in this byte
   logic [7:0] sr_q, sr_d;             // Shift register, both ways
   logic sda_oe_n_q, sda_oe_n_d;       // Low while pulling data low
   logic [3:0] op_q, op_d;             // Latched opcode
   logic [1:0] reg_q, reg_d;           // Latched register select
   logic [1:0] pot_q, pot_d;           // Latched pot select
   logic [5:0] data_q, data_d;         // Received setting bits
   logic pend_q, pend_d;               // Command waits for stop
   logic step_arm_q, step_arm_d;       // Step seen at clock rise
   logic step_up_q, step_up_d;         // Direction of that step
   logic [3:0] dsel_q1, dsel_q2;       // Select pin synchroniser
   logic nv_busy_q, nv_busy_d;         // Nonvolatile write running
   logic [CNT_W-1:0] nv_cnt_q, nv_cnt_d;
   logic [5:0] wiper_q [qpc_pkg::POTS];
   logic [5:0] wiper_d [qpc_pkg::POTS];
   // Nonvolatile store: untouched by reset; erased part reads zero
   // sixteen nonvolatile settings
   logic [5:0] set_q [qpc_pkg::POTS][qpc_pkg::SETS] = '{default: 6'h00};
   logic [5:0] set_d [qpc_pkg::POTS][qpc_pkg::SETS];
   logic [255:0] tap_q, tap_d;
   logic addr_ok;                      // Address byte is ours
   logic nv_start;                     // Begin nonvolatile write

   // Select pins come from outside, two flops first
   always_ff @(posedge clock_in) begin
      dsel_q1 <= device_select_bits_in;
      dsel_q2 <= dsel_q1;
   end

   // type and select match, not while busy
   assign addr_ok = (sr_q[qpc_pkg::TYPE_MSB:qpc_pkg::TYPE_LSB] == DEVICE_TYPE)
      && (sr_q[qpc_pkg::SEL_MSB:qpc_pkg::SEL_LSB] == dsel_q2) && !nv_busy_q;

   // Protocol, registers and commands
   always_comb begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      sr_d = sr_q;
      sda_oe_n_d = sda_oe_n_q;
      op_d = op_q;
      reg_d = reg_q;
      pot_d = pot_q;
      data_d = data_q;
      pend_d = pend_q;
      step_arm_d = step_arm_q;
      step_up_d = step_up_q;
      wiper_d = wiper_q;
      set_d = set_q;
      nv_start = 1'b0;
      if (lnk.start) begin
         // Start from anywhere drops an unfinished command
         state_d = qpc_pkg::ST_ADDR;
         bit_cnt_d = qpc_pkg::CNT_RST;
         sda_oe_n_d = 1'b1;
         pend_d = 1'b0;
         step_arm_d = 1'b0;
      end else if (lnk.stop) begin
         state_d = qpc_pkg::ST_IDLE;
         sda_oe_n_d = 1'b1;
         pend_d = 1'b0;
         step_arm_d = 1'b0;
         // Commands finish here, after the stop
         if (pend_q) begin
            case (op_q)
               qpc_pkg::OP_WR_SET: begin
                  set_d[pot_q][reg_q] = data_q;
                  nv_start = 1'b1;
               end
               qpc_pkg::OP_LOAD_SET: wiper_d[pot_q] = set_q[pot_q][reg_q];
               qpc_pkg::OP_SAVE_WIPER: begin
                  set_d[pot_q][reg_q] = wiper_q[pot_q];
                  nv_start = 1'b1;
               end
               qpc_pkg::OP_GLOAD_SET: begin
                  for (int p = 0; p < qpc_pkg::POTS; p++) begin
                     wiper_d[p] = set_q[p][reg_q];
                  end
               end
               qpc_pkg::OP_GSAVE_WIPER: begin
                  for (int p = 0; p < qpc_pkg::POTS; p++) begin
                     set_d[p][reg_q] = wiper_q[p];
                  end
                  nv_start = 1'b1;
               end
               default: nv_start = 1'b0;
            endcase
         end
      end else begin
         case (state_q)
            // Receiving bytes: sample at rise, ack after 8th fall
            qpc_pkg::ST_ADDR, qpc_pkg::ST_INSTR, qpc_pkg::ST_DRX: begin
               if (lnk.scl_rise && bit_cnt_q < 4'(qpc_pkg::BYTE_BITS)) begin
                  sr_d = {sr_q[6:0], lnk.sda_level};
                  bit_cnt_d = bit_cnt_q + 4'h1;
               end else if (lnk.scl_fall &&
                  bit_cnt_q == 4'(qpc_pkg::BYTE_BITS)) begin
                  bit_cnt_d = qpc_pkg::CNT_RST;
                  if (state_q == qpc_pkg::ST_ADDR) begin
                     state_d = addr_ok ? qpc_pkg::ST_ACK_A : qpc_pkg::ST_IDLE;
                     sda_oe_n_d = !addr_ok;
                  end else if (state_q == qpc_pkg::ST_INSTR) begin
                     op_d = sr_q[qpc_pkg::OP_MSB:qpc_pkg::OP_LSB];
                     reg_d = sr_q[qpc_pkg::REG_MSB:qpc_pkg::REG_LSB];
                     pot_d = sr_q[qpc_pkg::POT_MSB:qpc_pkg::POT_LSB];
                     // unknown opcode: no ack, back to idle
                     if (qpc_pkg::op_known(
                        sr_q[qpc_pkg::OP_MSB:qpc_pkg::OP_LSB])) begin
                        state_d = qpc_pkg::ST_ACK_I;
                        sda_oe_n_d = 1'b0;
                     end else begin
                        state_d = qpc_pkg::ST_IDLE;
                     end
                  end else begin
                     // ack data; top two bits ignored
                     state_d = qpc_pkg::ST_ACK_D;
                     sda_oe_n_d = 1'b0;
                     data_d = sr_q[5:0];
                     if (op_q == qpc_pkg::OP_WR_WIPER) begin
                        wiper_d[pot_q] = sr_q[5:0];
                     end
                  end
               end
            end
            // address acked, release at next fall
            qpc_pkg::ST_ACK_A: begin
               if (lnk.scl_fall) begin
                  state_d = qpc_pkg::ST_INSTR;
                  sda_oe_n_d = 1'b1;
               end
            end
            // Instruction acked; branch by opcode
            qpc_pkg::ST_ACK_I: begin
               if (lnk.scl_fall) begin
                  sda_oe_n_d = 1'b1;
                  case (op_q)
                     qpc_pkg::OP_RD_WIPER, qpc_pkg::OP_RD_SET: begin
                        // two zeros, then six bits, MSB first
                        sr_d = (op_q == qpc_pkg::OP_RD_WIPER) ?
                           {2'b00, wiper_q[pot_q]} :
                           {2'b00, set_q[pot_q][reg_q]};
                        sda_oe_n_d = sr_d[7];
                        sr_d = {sr_d[6:0], 1'b0};
                        bit_cnt_d = 4'h1;
                        state_d = qpc_pkg::ST_DTX;
                     end
                     qpc_pkg::OP_WR_WIPER, qpc_pkg::OP_WR_SET: begin
                        bit_cnt_d = qpc_pkg::CNT_RST;
                        state_d = qpc_pkg::ST_DRX;
                     end
                     qpc_pkg::OP_STEP: state_d = qpc_pkg::ST_STEP;
                     default: begin
                        // Two-byte transfers wait for the stop
                        pend_d = 1'b1;
                        state_d = qpc_pkg::ST_IDLE;
                     end
                  endcase
               end
            end
            // Data acked; write-setting waits for the stop
            qpc_pkg::ST_ACK_D: begin
               if (lnk.scl_fall) begin
                  sda_oe_n_d = 1'b1;
                  pend_d = (op_q == qpc_pkg::OP_WR_SET);
                  state_d = qpc_pkg::ST_IDLE;
               end
            end
            // Sending data; master ack ignored, stop expected
            qpc_pkg::ST_DTX: begin
               if (lnk.scl_fall) begin
                  if (bit_cnt_q == 4'(qpc_pkg::BYTE_BITS)) begin
                     sda_oe_n_d = 1'b1;
                     state_d = qpc_pkg::ST_IDLE;
                  end else begin
                     sda_oe_n_d = sr_q[7];
                     sr_d = {sr_q[6:0], 1'b0};
                     bit_cnt_d = bit_cnt_q + 4'h1;
                  end
               end
            end
            // level at rise picks direction, fall applies it
            qpc_pkg::ST_STEP: begin
               if (lnk.scl_rise) begin
                  step_arm_d = 1'b1;
                  step_up_d = lnk.sda_level;
               end else if (lnk.scl_fall && step_arm_q) begin
                  step_arm_d = 1'b0;
                  if (step_up_q && wiper_q[pot_q] != qpc_pkg::WIPER_MAX) begin
                     wiper_d[pot_q] = wiper_q[pot_q] + 6'h01;
                  end else if (!step_up_q &&
                     wiper_q[pot_q] != qpc_pkg::WIPER_MIN) begin
                     wiper_d[pot_q] = wiper_q[pot_q] - 6'h01;
                  end
               end
            end
            default: state_d = state_q;
         endcase
      end
      if (reset_in) begin
         state_d = qpc_pkg::ST_IDLE;
         bit_cnt_d = qpc_pkg::CNT_RST;
         sr_d = qpc_pkg::SHIFT_RST;
         sda_oe_n_d = 1'b1;
         op_d = qpc_pkg::LINE_RST;
         reg_d = 2'h0;
         pot_d = 2'h0;
         data_d = qpc_pkg::WIPER_MIN;
         pend_d = 1'b0;
         step_arm_d = 1'b0;
         step_up_d = 1'b0;
         set_d = set_q;
         nv_start = 1'b0;
         // wipers come back from setting zero
         for (int p = 0; p < qpc_pkg::POTS; p++) begin
            wiper_d[p] = set_q[p][0];
         end
      end
   end

   // busy for the full write time, then free
   always_comb begin
      nv_busy_d = nv_busy_q;
      nv_cnt_d = nv_cnt_q;
      if (nv_start) begin
         nv_busy_d = 1'b1;
         nv_cnt_d = CNT_W'(NV_WRITE_CYCLES - 1);
      end else if (nv_busy_q) begin
         if (nv_cnt_q == '0) begin
            nv_busy_d = 1'b0;
         end else begin
            nv_cnt_d = nv_cnt_q - CNT_W'(1);
         end
      end
      // Power loss ends the busy time; the new setting is kept
      if (reset_in) begin
         nv_busy_d = 1'b0;
         nv_cnt_d = '0;
      end
   end

   always_comb begin
      tap_d = '0;
      for (int p = 0; p < qpc_pkg::POTS; p++) begin
         tap_d[p*qpc_pkg::TAPS +: qpc_pkg::TAPS] =
            reset_in ? 64'h0 : qpc_pkg::tap_decode(wiper_q[p]);
      end
   end

   // Register only
   always_ff @(posedge clock_in) begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      sr_q <= sr_d;
      sda_oe_n_q <= sda_oe_n_d;
      op_q <= op_d;
      reg_q <= reg_d;
      pot_q <= pot_d;
      data_q <= data_d;
      pend_q <= pend_d;
      step_arm_q <= step_arm_d;
      step_up_q <= step_up_d;
      wiper_q <= wiper_d;
      set_q <= set_d;
      nv_busy_q <= nv_busy_d;
      nv_cnt_q <= nv_cnt_d;
      tap_q <= tap_d;
   end

   // Open-drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe_n_out = sda_oe_n_q;
   assign nv_busy_out = nv_busy_q;
   assign tap_select_out = tap_q;
   always_comb begin
      for (int p = 0; p < qpc_pkg::POTS; p++) begin
         wiper_position_bits_out[p*qpc_pkg::POS_W +: qpc_pkg::POS_W] =
            wiper_q[p];
      end
   end

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (reset_in);

   a_tap_one_closed: assert property (
      !$past(reset_in) |-> $countones(tap_q[63:0]) == 1)
      else $error("pot 0 tap select not single");
   a_wiper_power_recall: assert property (
      $past(reset_in) |-> wiper_q[0] == $past(set_q[0][0]))
      else $error("wiper not recalled from setting zero");
   a_busy_no_ack: assert property (
      (state_q == qpc_pkg::ST_ADDR && lnk.scl_fall && bit_cnt_q == 4'h8
       && nv_busy_q) |=> sda_oe_n_q && state_q == qpc_pkg::ST_IDLE)
      else $error("address acked during write");
   a_busy_bounded: assert property (
      nv_busy_q |-> nv_cnt_q < CNT_W'(NV_WRITE_CYCLES))
      else $error("write counter out of range");
   // Selects and wiper hold across the stop, so compare after it
   a_save_starts_busy: assert property (
      (lnk.stop && pend_q && op_q == qpc_pkg::OP_SAVE_WIPER)
      |=> nv_busy_q && set_q[pot_q][reg_q] == wiper_q[pot_q])
      else $error("wiper save missing");
   a_step_top_hold: assert property (
      (state_q == qpc_pkg::ST_STEP && lnk.scl_fall && step_arm_q
       && step_up_q && wiper_q[pot_q] == qpc_pkg::WIPER_MAX && !lnk.stop
       && !lnk.start) |=> wiper_q[pot_q] == qpc_pkg::WIPER_MAX)
      else $error("wiper wrapped past top");
   a_wiper_direct_load: assert property (
      (state_q == qpc_pkg::ST_DRX && lnk.scl_fall && bit_cnt_q == 4'h8
       && op_q == qpc_pkg::OP_WR_WIPER && !lnk.start && !lnk.stop)
      |=> wiper_q[pot_q] == $past(sr_q[5:0]) ##1 !sda_oe_n_q)
      else $error("wiper write lost");
   a_read_lead_zeros: assert property (
      (state_q == qpc_pkg::ST_DTX && bit_cnt_q <= 4'h2) |-> !sda_oe_n_q)
      else $error("read byte lead bits not zero");
   a_unknown_op_idle: assert property (
      (state_q == qpc_pkg::ST_INSTR && lnk.scl_fall && bit_cnt_q == 4'h8
       && !qpc_pkg::op_known(sr_q[7:4]) && !lnk.start && !lnk.stop)
      |=> state_q == qpc_pkg::ST_IDLE && sda_oe_n_q && !pend_q)
      else $error("unknown opcode acted upon");

   c_write_wiper: cover property (state_q == qpc_pkg::ST_ACK_D
      && op_q == qpc_pkg::OP_WR_WIPER);
   c_read_setting: cover property (state_q == qpc_pkg::ST_DTX
      && op_q == qpc_pkg::OP_RD_SET);
   c_step_taken: cover property (state_q == qpc_pkg::ST_STEP
      && lnk.scl_fall && step_arm_q);
   c_nv_write: cover property ($rose(nv_busy_q));
endmodule : qpc_core
`default_nettype wire

//--- bench/qpc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master: drives the clock line and pulls the data line low
module qpc_master_model (
   input wire logic clock_in,
   input wire logic sda_line_in,
   output logic scl_out,
   output logic sda_out
);
   // Both lines idle high; clock stands still between frames
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Moves just after the system edge, always the same skew
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : tick
   // One bit: six cycles low, two high; line read at the rise
   task automatic put_bit(input logic b, output logic seen);
      tick(1);
      sda_out = b;
      tick(5);
      scl_out = 1'b1;
      seen = sda_line_in;
      tick(2);
      scl_out = 1'b0;
   endtask : put_bit
   // Data falls while clock high
   task automatic start_c();
      tick(4);
      sda_out = 1'b0;
      tick(4);
      scl_out = 1'b0;
   endtask : start_c
   // Data rises while clock high; a high phase with data low first
   task automatic stop_c();
      tick(1);
      sda_out = 1'b0;
      tick(5);
      scl_out = 1'b1;
      tick(4);
      sda_out = 1'b1;
      tick(4);
   endtask : stop_c
   // byte sent as given, zeros in unused places, MSB first
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(b[i], s);
      put_bit(1'b1, s);
      ack = ~s;
   endtask : put_byte
   // caller gives the answer slot level; low acknowledges
   task automatic get_byte(input logic ack_level, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, s);
         d[i] = s;
      end
      put_bit(ack_level, s);
   endtask : get_byte
endmodule : qpc_master_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   // Short write time keeps the run brief; longer than one poll byte
   localparam int NV_CYC = 200;
   localparam logic [3:0] SEL = 4'h6;
   localparam logic [7:0] ADR = {qpc_pkg::DEVICE_TYPE_DEF, SEL};
   typedef struct packed {logic [1:0] pot; logic [5:0] val;} qpc_row_type;
   localparam qpc_row_type ROWS [4] = '{'{2'h0, 6'h00}, '{2'h1, 6'h3F},
      '{2'h2, 6'h15}, '{2'h3, 6'h2A}};
   localparam logic [5:0] S0 [4] = '{6'h05, 6'h3A, 6'h11, 6'h2C};
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic scl, m_sda, sda_line, dut_sda, sda_oe_n, busy;
   logic [23:0] wipers;
   logic [255:0] taps;
   logic [7:0] rd;
   logic ok;
   logic [3:0] sel_pins = SEL; // Select strap pins
   int bad_count = 0;
   int total_checks = 0;
   always #10 clock_in = ~clock_in;
   // Open drain, no pull-up: while the core releases, the line follows the master
   assign sda_line = sda_oe_n ? m_sda : dut_sda;
   qpc_core #(.NV_WRITE_CYCLES(NV_CYC)) i_dut (.clock_in(clock_in),
      .reset_in(reset_in), .scl_in(scl), .sda_in(sda_line),
      .sda_out(dut_sda), .sda_oe_n_out(sda_oe_n),
      .device_select_bits_in(sel_pins), .wiper_position_bits_out(wipers),
      .tap_select_out(taps), .nv_busy_out(busy));
   qpc_master_model i_master (.clock_in(clock_in), .sda_line_in(sda_line),
      .scl_out(scl), .sda_out(m_sda));
   task automatic check(input string name, input logic [63:0] seen,
      input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_sim();
      $display("Checks %0d, errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   // Kind: 0 two bytes, 1 data written, 2 data read, 3 address only
   task automatic frame(input logic [7:0] adr, input logic [7:0] ins,
      input int kind, input logic [7:0] wd, output logic good,
      output logic [7:0] d);
      logic a1, a2, a3;
      a2 = 1'b1;
      a3 = 1'b1;
      d = 8'h00;
      i_master.start_c();
      i_master.put_byte(adr, a1);
      if (a1 && kind != 3) i_master.put_byte(ins, a2);
      if (a1 && a2 && kind == 1) i_master.put_byte(wd, a3);
      if (a1 && a2 && kind == 2) i_master.get_byte(1'b0, d);
      i_master.stop_c();
      good = a1 && a2 && a3;
   endtask : frame
   task automatic cmd(input logic [3:0] op, input logic [1:0] r,
      input logic [1:0] p, input int kind, input logic [7:0] wd);
      frame(ADR, {op, r, p}, kind, wd, ok, rd);
      check("frame ack", ok, 1'b1);
   endtask : cmd
   // Bounded wait for the end of a nonvolatile write
   task automatic nv_wait();
      int n;
      n = 0;
      while (busy === 1'b1 && n < 400) begin
         @(posedge clock_in);
         #1;
         n++;
      end
      check("busy span", n <= NV_CYC, 1'b1);
   endtask : nv_wait
   // Step mode: n high phases with one data level, then stop
   task automatic step(input logic [1:0] p, input int n, input logic up);
      logic s, a1, a2;
      i_master.start_c();
      i_master.put_byte(ADR, a1);
      i_master.put_byte({qpc_pkg::OP_STEP, 2'b00, p}, a2);
      repeat (n) i_master.put_bit(up, s);
      i_master.stop_c();
      check("step ack", a1 && a2, 1'b1);
   endtask : step
   initial begin
      repeat (8) @(posedge clock_in);
      #1;
      reset_in = 1'b0;
      i_master.tick(3);
      // Setting zero of each pot, with ack polling after the first
      for (int p = 0; p < 4; p++) begin
         cmd(qpc_pkg::OP_WR_SET, 2'b00, p[1:0], 1, {2'b00, S0[p]});
         check("busy", busy, 1'b1);
         if (p == 0) begin
            frame(ADR, 8'h00, 3, 8'h00, ok, rd);
            check("poll busy", ok, 1'b0);
         end
         nv_wait();
      end
      frame(ADR, 8'h00, 3, 8'h00, ok, rd);
      check("poll free", ok, 1'b1);
      reset_in = 1'b1;
      i_master.tick(8);
      check("taps reset", |taps, 1'b0);
      reset_in = 1'b0;
      i_master.tick(3);
      check("power up", wipers, {S0[3], S0[2], S0[1], S0[0]});
      // Ordinary cases: write a wiper, see it and its tap, read it
      foreach (ROWS[i]) begin
         cmd(qpc_pkg::OP_WR_WIPER, 2'b00, ROWS[i].pot, 1,
            {2'b00, ROWS[i].val});
         check("wiper", wipers[6*ROWS[i].pot +: 6], ROWS[i].val);
         check("tap", taps[64*ROWS[i].pot +: 64], 64'h1 << ROWS[i].val);
         cmd(qpc_pkg::OP_RD_WIPER, 2'b00, ROWS[i].pot, 2, 8'h00);
         check("read wiper", rd, {2'b00, ROWS[i].val});
      end
      cmd(qpc_pkg::OP_GLOAD_SET, 2'b00, 2'b00, 0, 8'h00);
      check("global load", wipers, {S0[3], S0[2], S0[1], S0[0]});
      cmd(qpc_pkg::OP_RD_SET, 2'b00, 2'h2, 2, 8'h00);
      check("read setting", rd, {2'b00, S0[2]});
      // Save one wiper into setting two, read it back
      cmd(qpc_pkg::OP_WR_WIPER, 2'b00, 2'h3, 1, 8'h27);
      cmd(qpc_pkg::OP_SAVE_WIPER, 2'b10, 2'h3, 0, 8'h00);
      nv_wait();
      cmd(qpc_pkg::OP_RD_SET, 2'b10, 2'h3, 2, 8'h00);
      check("saved wiper", rd, 8'h27);
      cmd(qpc_pkg::OP_LOAD_SET, 2'b00, 2'h3, 0, 8'h00);
      check("transfer", wipers[23:18], S0[3]);
      // Global save into setting one, single write
      cmd(qpc_pkg::OP_GSAVE_WIPER, 2'b01, 2'b00, 0, 8'h00);
      nv_wait();
      cmd(qpc_pkg::OP_RD_SET, 2'b01, 2'h1, 2, 8'h00);
      check("global save", rd, {2'b00, S0[1]});
      // Stepping saturates at both ends
      cmd(qpc_pkg::OP_WR_WIPER, 2'b00, 2'h1, 1, 8'h3E);
      step(2'h1, 3, 1'b1);
      check("step top", wipers[11:6], 6'h3F);
      step(2'h1, 2, 1'b0);
      check("step down", wipers[11:6], 6'h3D);
      step(2'h0, 7, 1'b0);
      check("step bottom", wipers[5:0], 6'h00);
      // Foreign select bits and foreign type are ignored
      frame({qpc_pkg::DEVICE_TYPE_DEF, 4'h7}, 8'h00, 3, 8'h00, ok, rd);
      check("other select", ok, 1'b0);
      // Strap pins moved: the same address now belongs to us
      sel_pins = 4'h7;
      frame({qpc_pkg::DEVICE_TYPE_DEF, 4'h7}, 8'h00, 3, 8'h00, ok, rd);
      check("moved pins", ok, 1'b1);
      sel_pins = SEL;
      frame(ADR ^ 8'h30, 8'h00, 3, 8'h00, ok, rd);
      check("other type", ok, 1'b0);
      frame(ADR, 8'h35, 1, 8'h01, ok, rd);
      check("bad opcode", ok, 1'b0);
      check("no change", wipers, {S0[3], S0[2], 6'h3D, 6'h00});
      end_sim();
   end
   // Watchdog, far beyond the expected run
   initial begin
      #1000000;
      bad_count++;
      end_sim();
   end
endmodule : tb
`default_nettype wire
